// ==== design/mbg_modem_glue.sv ====
// modem board glue: local bus decode, level shifter direction, mailbox
// interrupts, code load control, local clock divider and one modem engine
// assumes all inputs synchronous to core_clk and a local bus slower than it
//
// What this block does
// - each modem is reached by muxed 8-bit bus, select, strobes, latch, interrupt
// - transmit bytes become a continuous 9600-baud synchronous serial stream
// - receiver interrupts the local cpu per complete assembled byte
// - receiver finds bit sync and word sync before delivering bytes
// - shifter outputs always enabled; lower section always points to modems
// - upper section points to modems, reversed only during a modem read
// - host port is 8-bit with separate dual-port ram and code selects
// - local cpu clock is the host output clock divided by two
// - host write to 1fff interrupts local cpu; local read clears it
// - local write to 1ffe interrupts the host
// - hold low keeps local cpu in reset and opens host code access
`default_nettype none
module mbg_modem_glue #(
  parameter logic [7:0] SYNC_WORD = 8'h7e,
  parameter int unsigned MODEM_SLOT = 0
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  // local cpu multiplexed bus
  input wire logic local_ale,
  input wire logic local_rd_n,
  input wire logic local_wr_n,
  input wire logic [7:0] local_addr_hi,
  input wire logic [7:0] local_ad_in,
  output logic [7:0] local_ad_out,
  output logic local_ad_oe_n,
  output logic local_cpu_clk,
  output logic local_cpu_reset_n,
  output logic local_cpu_mailbox_irq_n,
  // chip selects toward memories and modems
  output logic dpr_local_cs_n,
  output logic data_ram_cs_n,
  output logic [2:0] modem_cs_n,
  output logic modem_irq_n,
  // level shifter control
  output logic lower_section_direction,
  output logic upper_section_direction,
  output logic shifter_oe_n,
  // host port
  input wire logic host_dpr_sel_n,
  input wire logic host_code_sel_n,
  input wire logic host_wr_n,
  input wire logic [12:0] host_addr,
  input wire logic local_cpu_hold_n,
  output logic host_mailbox_irq_n,
  output logic code_ram_cs_n,
  output logic code_xcvr_en_n,
  // serial link of the modem engine
  input wire logic rx_serial,
  output logic tx_serial,
  output logic tx_bit_clk
);
  if (MODEM_SLOT >= mbg_pkg::MODEM_COUNT) begin : g_chk
    $error("mbg_modem_glue: MODEM_SLOT must name one of the three modems");
  end

  typedef struct packed {
    logic lclk;
    logic hold_n;
    logic code_en_n;
    logic code_cs_n;
    logic [7:0] addr_lo;
    logic rd_q;
    logic wr_q;
    logic hwr_q;
    logic mbx_local;
    logic mbx_host;
    logic dir_up;
    logic [7:0] ad_out;
    logic ad_oe_n;
    logic dpr_cs_n;
    logic data_cs_n;
    logic [2:0] mdm_cs_n;
    logic mdm_irq_n;
    logic [10:0] tx_cnt;
    logic [2:0] tx_bit;
    logic [7:0] tx_shift;
    logic tx_line;
    logic tx_clk;
    logic rx_q;
    logic [10:0] rx_cnt;
    logic [7:0] rx_shift;
    logic rx_sync;
    logic [2:0] rx_bits;
    logic [7:0] rx_byte;
    logic rx_full;
    logic rx_overrun;
  } mbg_glue_s;

  mbg_glue_s state_reg;
  mbg_glue_s state_next;

  mbg_stream_if #(.WIDTH(mbg_pkg::TXBUF_WIDTH)) tx_in ();
  mbg_stream_if #(.WIDTH(mbg_pkg::TXBUF_WIDTH)) tx_out ();

  // region of a local address, shared by the dual-port ram and modem chip-select decodes
  function automatic logic region_is(input logic [7:0] hi, input logic [2:0] region);
    return (hi[7:5] == region);
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // tx buffer: a slow consumer holds bytes, the interrupt then stays quiet
  mbg_pair_buf #(.WIDTH(mbg_pkg::TXBUF_WIDTH)) u_txbuf (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .fill(tx_in.snk),
    .drain(tx_out.src)
  );

  logic rd_act;
  logic wr_act;
  logic rd_start;
  logic wr_start;
  logic [15:0] laddr;
  logic own_sel;
  logic any_modem;
  logic host_wr_start;
  logic tx_tick;
  logic rx_tick;
  logic [7:0] rx_shift_new;

  // strobe edges so a long strobe acts only once
  assign rd_act = !local_rd_n;
  assign wr_act = !local_wr_n;
  assign rd_start = rd_act && !state_reg.rd_q;
  assign wr_start = wr_act && !state_reg.wr_q;
  assign laddr = {local_addr_hi, state_reg.addr_lo};
  assign own_sel = region_is(local_addr_hi, mbg_pkg::REGION_MODEM0 + 3'(MODEM_SLOT));
  assign any_modem = !local_addr_hi[7] && (local_addr_hi[6:5] != 2'h0);
  assign host_wr_start = !host_dpr_sel_n && !host_wr_n && !state_reg.hwr_q;
  assign tx_tick = (state_reg.tx_cnt == '0);
  assign rx_tick = (state_reg.rx_cnt == '0) && (state_reg.rx_q == rx_serial);
  assign rx_shift_new = {state_reg.rx_shift[6:0], rx_serial};

  // byte pushed on the data write; refused when full, hence irq first
  assign tx_in.valid = wr_start && own_sel && (laddr[1:0] == mbg_pkg::MDM_DATA_OFS);
  assign tx_in.data = local_ad_in;
  assign tx_out.ready = tx_tick && (state_reg.tx_bit == 3'h7);

  always_comb begin
    state_next = state_reg;
    state_next.lclk = !state_reg.lclk;
    state_next.hold_n = local_cpu_hold_n;
    state_next.code_en_n = local_cpu_hold_n;
    // host code access only passes while the local cpu is held
    state_next.code_cs_n = host_code_sel_n || local_cpu_hold_n;
    state_next.rd_q = rd_act;
    state_next.wr_q = wr_act;
    state_next.hwr_q = !host_dpr_sel_n && !host_wr_n;
    if (local_ale) state_next.addr_lo = local_ad_in;

    // chip selects follow the strobes
    state_next.dpr_cs_n = !((rd_act || wr_act) && region_is(local_addr_hi, mbg_pkg::REGION_DPR));
    state_next.data_cs_n = !((rd_act || wr_act) && local_addr_hi[7]);
    for (int i = 0; i < int'(mbg_pkg::MODEM_COUNT); i++) begin
      state_next.mdm_cs_n[i] = !((rd_act || wr_act) &&
        region_is(local_addr_hi, mbg_pkg::REGION_MODEM0 + 3'(i)));
    end

    // upper section turns only for a modem read; high again once rd ends,
    // one core cycle, well inside the local bus gap before any write
    state_next.dir_up = !(rd_act && any_modem);

    // mailbox to local cpu: set wins over a simultaneous clear
    if (rd_start && region_is(local_addr_hi, mbg_pkg::REGION_DPR) &&
        laddr[12:0] == mbg_pkg::MBX_TO_LOCAL) begin
      state_next.mbx_local = 1'b0;
    end
    if (host_wr_start && host_addr == mbg_pkg::MBX_TO_LOCAL) begin
      state_next.mbx_local = 1'b1;
    end
    // mailbox to host: host read of its word clears, local write sets
    if (!host_dpr_sel_n && host_wr_n && host_addr == mbg_pkg::MBX_TO_HOST) begin
      state_next.mbx_host = 1'b0;
    end
    if (wr_start && region_is(local_addr_hi, mbg_pkg::REGION_DPR) &&
        laddr[12:0] == mbg_pkg::MBX_TO_HOST) begin
      state_next.mbx_host = 1'b1;
    end

    // read data of the own modem engine, driven only during its read
    state_next.ad_oe_n = !(rd_act && own_sel);
    if (rd_act && own_sel) begin
      if (laddr[1:0] == mbg_pkg::MDM_DATA_OFS) begin
        state_next.ad_out = state_reg.rx_byte;
      end else if (laddr[1:0] == mbg_pkg::MDM_STAT_OFS) begin
        state_next.ad_out = '0;
        state_next.ad_out[mbg_pkg::STAT_RX_FULL] = state_reg.rx_full;
        state_next.ad_out[mbg_pkg::STAT_TX_ROOM] = tx_in.ready;
        state_next.ad_out[mbg_pkg::STAT_WORD_SYNC] = state_reg.rx_sync;
        state_next.ad_out[mbg_pkg::STAT_OVERRUN] = state_reg.rx_overrun;
      end else begin
        state_next.ad_out = '0;
      end
    end
    // reading data or status acknowledges; a new byte still wins
    if (rd_start && own_sel && laddr[1:0] == mbg_pkg::MDM_DATA_OFS) begin
      state_next.rx_full = 1'b0;
    end
    if (rd_start && own_sel && laddr[1:0] == mbg_pkg::MDM_STAT_OFS) begin
      state_next.rx_overrun = 1'b0;
    end

    // transmitter: never idles, fills gaps with the sync word
    if (tx_tick) begin
      state_next.tx_cnt = mbg_pkg::BIT_RELOAD;
      state_next.tx_line = state_reg.tx_shift[7];
      state_next.tx_bit = state_reg.tx_bit + 3'h1;
      if (state_reg.tx_bit == 3'h7) begin
        state_next.tx_shift = tx_out.valid ? tx_out.data : SYNC_WORD;
      end else begin
        state_next.tx_shift = {state_reg.tx_shift[6:0], 1'b0};
      end
    end else begin
      state_next.tx_cnt = state_reg.tx_cnt - 11'h1;
    end
    // bit clock low for the first half, rises mid-bit for the far sampler
    state_next.tx_clk = (state_next.tx_cnt < mbg_pkg::BIT_HALF);

    // receiver bit sync: each line edge re-centres the sample point
    state_next.rx_q = rx_serial;
    if (state_reg.rx_q != rx_serial) begin
      state_next.rx_cnt = mbg_pkg::BIT_HALF;
    end else if (state_reg.rx_cnt == '0) begin
      state_next.rx_cnt = mbg_pkg::BIT_RELOAD;
    end else begin
      state_next.rx_cnt = state_reg.rx_cnt - 11'h1;
    end
    // word sync by hunting the sync word, then byte framing
    if (rx_tick) begin
      state_next.rx_shift = rx_shift_new;
      if (!state_reg.rx_sync) begin
        if (rx_shift_new == SYNC_WORD) begin
          state_next.rx_sync = 1'b1;
          state_next.rx_bits = 3'h0;
        end
      end else begin
        state_next.rx_bits = state_reg.rx_bits + 3'h1;
        if (state_reg.rx_bits == 3'h7) begin
          state_next.rx_byte = rx_shift_new;
          state_next.rx_full = 1'b1;
          if (state_reg.rx_full) state_next.rx_overrun = 1'b1;
        end
      end
    end

    // one interrupt: byte waiting or room for a tx byte
    state_next.mdm_irq_n = !(state_next.rx_full || tx_in.ready);
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      state_reg <= '0;
      state_reg.hold_n <= 1'b0;
      state_reg.code_en_n <= 1'b1;
      state_reg.code_cs_n <= 1'b1;
      state_reg.dir_up <= 1'b1;
      state_reg.ad_oe_n <= 1'b1;
      state_reg.dpr_cs_n <= 1'b1;
      state_reg.data_cs_n <= 1'b1;
      state_reg.mdm_cs_n <= 3'h7;
      state_reg.mdm_irq_n <= 1'b1;
      state_reg.tx_line <= 1'b1;
      state_reg.rx_cnt <= mbg_pkg::BIT_RELOAD;
      state_reg.tx_cnt <= mbg_pkg::BIT_RELOAD;
      state_reg.tx_bit <= 3'h7;
    end else if (clk_en) begin
      state_reg <= state_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs straight from the state flops
  assign local_ad_out = state_reg.ad_out;
  assign local_ad_oe_n = state_reg.ad_oe_n;
  assign local_cpu_clk = state_reg.lclk;
  assign local_cpu_reset_n = state_reg.hold_n;
  assign local_cpu_mailbox_irq_n = !state_reg.mbx_local;
  assign dpr_local_cs_n = state_reg.dpr_cs_n;
  assign data_ram_cs_n = state_reg.data_cs_n;
  assign modem_cs_n = state_reg.mdm_cs_n;
  assign modem_irq_n = state_reg.mdm_irq_n;
  // constant levels leave reset-free flops out; lower direction and shifter enable never change
  assign lower_section_direction = 1'b1;
  assign shifter_oe_n = 1'b0;
  assign upper_section_direction = state_reg.dir_up;
  assign host_mailbox_irq_n = !state_reg.mbx_host;
  assign code_ram_cs_n = state_reg.code_cs_n;
  assign code_xcvr_en_n = state_reg.code_en_n;
  assign tx_serial = state_reg.tx_line;
  assign tx_bit_clk = state_reg.tx_clk;
endmodule // mbg_modem_glue
`default_nettype wire

// ==== design/mbg_pkg.sv ====
// constants shared by the modem board glue and its tx buffer
// assumes one 10 MHz core clock that also stands for the host output clock
`default_nettype none
package mbg_pkg;
  // core clock and serial timing
  localparam int unsigned CORE_CLK_HZ = 10_000_000;
  localparam int unsigned MODEM_BAUD = 9600;
  // longest whole bit period, rounded down
  localparam int unsigned BIT_CYCLES = CORE_CLK_HZ / MODEM_BAUD;
  localparam int unsigned HALF_BIT_CYCLES = BIT_CYCLES / 2;
  localparam int unsigned BIT_CNT_W = 11;
  localparam logic [10:0] BIT_RELOAD = 11'(BIT_CYCLES - 1);
  localparam logic [10:0] BIT_HALF = 11'(HALF_BIT_CYCLES);
  // local cpu clock: host output clock divided by two
  localparam int unsigned LOCAL_CLK_DIV = 2;
  // local address map, region = address bits 15..13
  localparam logic [2:0] REGION_DPR = 3'h0;
  localparam logic [2:0] REGION_MODEM0 = 3'h1;
  localparam int unsigned MODEM_COUNT = 3;
  // mailbox words inside the 8k dual-port ram
  localparam int unsigned DPR_ADDR_W = 13;
  localparam logic [12:0] MBX_TO_LOCAL = 13'h1fff;
  localparam logic [12:0] MBX_TO_HOST = 13'h1ffe;
  // modem engine register offsets, address bits 1..0
  localparam logic [1:0] MDM_DATA_OFS = 2'h0;
  localparam logic [1:0] MDM_STAT_OFS = 2'h1;
  // status field positions
  localparam int unsigned STAT_RX_FULL = 0;
  localparam int unsigned STAT_TX_ROOM = 1;
  localparam int unsigned STAT_WORD_SYNC = 2;
  localparam int unsigned STAT_OVERRUN = 3;
  // tx buffer
  localparam int unsigned TXBUF_WIDTH = 8;
endpackage
`default_nettype wire

// ==== design/mbg_stream_if.sv ====
// valid/ready byte stream between the glue and its tx buffer
// assumes both ends share one clock
`default_nettype none
interface mbg_stream_if #(parameter int unsigned WIDTH = 8);
  logic valid;
  logic ready;
  logic [WIDTH-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// ==== design/mbg_pair_buf.sv ====
// two-entry buffer with valid and ready on both sides
// assumes synchronous active-low reset and a shared clock enable
`default_nettype none
module mbg_pair_buf #(
  parameter int unsigned WIDTH = 8
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  mbg_stream_if.snk fill,
  mbg_stream_if.src drain
);
  if (WIDTH < 1) begin : g_chk
    $error("mbg_pair_buf: WIDTH must be at least 1");
  end

  typedef struct packed {
    logic [WIDTH-1:0] head;
    logic [WIDTH-1:0] tail;
    logic [1:0] count;
  } mbg_buf_s;

  mbg_buf_s state_reg;
  mbg_buf_s state_next;
  logic push;
  logic pop;

  //////////////////////////////////////////////////////////////////////////////
  // honest flags: full refuses, empty shows no valid
  assign fill.ready = (state_reg.count != 2'h2);
  assign drain.valid = (state_reg.count != 2'h0);
  assign drain.data = state_reg.head;
  assign push = fill.valid && fill.ready;
  assign pop = drain.valid && drain.ready;

  // head always holds the oldest word
  always_comb begin
    state_next = state_reg;
    unique case ({push, pop})
      2'b10: begin
        if (state_reg.count == 2'h0) state_next.head = fill.data;
        else state_next.tail = fill.data;
        state_next.count = state_reg.count + 2'h1;
      end
      2'b01: begin
        state_next.head = state_reg.tail;
        state_next.count = state_reg.count - 2'h1;
      end
      2'b11: begin
        // count stays; a lone word is replaced, a pair shifts
        if (state_reg.count == 2'h1) begin
          state_next.head = fill.data;
        end else begin
          state_next.head = state_reg.tail;
          state_next.tail = fill.data;
        end
      end
      2'b00: ;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) state_reg <= '0;
    else if (clk_en) state_reg <= state_next;
  end
endmodule // mbg_pair_buf
`default_nettype wire

// ==== test/mbg_glue_sva.sv ====
// concurrent checks on the modem board glue top ports
// assumes clk_en held high by the bench, one clock domain
`default_nettype none
module mbg_glue_sva (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic local_ale,
  input wire logic local_rd_n,
  input wire logic local_wr_n,
  input wire logic [7:0] local_addr_hi,
  input wire logic [7:0] local_ad_in,
  input wire logic local_cpu_clk,
  input wire logic local_cpu_reset_n,
  input wire logic local_cpu_mailbox_irq_n,
  input wire logic [2:0] modem_cs_n,
  input wire logic lower_section_direction,
  input wire logic upper_section_direction,
  input wire logic shifter_oe_n,
  input wire logic host_dpr_sel_n,
  input wire logic host_wr_n,
  input wire logic [12:0] host_addr,
  input wire logic local_cpu_hold_n,
  input wire logic host_mailbox_irq_n,
  input wire logic code_ram_cs_n,
  input wire logic code_xcvr_en_n,
  input wire logic tx_bit_clk
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] lo_reg;
  logic bclk_reg;
  logic seen_reg;
  logic [10:0] bc_reg;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  ////////////////////////////////////////////////////////////////////////////
  // low address byte and bit clock period counter, seen skips the first rise
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      lo_reg <= 8'h00;
      bclk_reg <= 1'b0;
      seen_reg <= 1'b0;
      bc_reg <= 11'h000;
    end else begin
      lo_reg <= local_ale ? local_ad_in : lo_reg;
      bclk_reg <= tx_bit_clk;
      seen_reg <= seen_reg | (tx_bit_clk & ~bclk_reg);
      bc_reg <= (tx_bit_clk && !bclk_reg) ? 11'h001 : bc_reg + 11'h001;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // strobe starts and host mailbox write as named steps
  sequence s_rd_start;
    $fell(local_rd_n);
  endsequence
  sequence s_strobe_start;
    $fell(local_rd_n) || $fell(local_wr_n);
  endsequence
  sequence s_host_mbx_wr;
    !host_dpr_sel_n && !host_wr_n && host_addr == mbg_pkg::MBX_TO_LOCAL
      && !$past(!host_dpr_sel_n && !host_wr_n);
  endsequence
  a_lower_fixed: assert property (lower_section_direction && !shifter_oe_n)
    else $error("lower section direction or enable wrong");
  a_upper_reverse: assert property (s_rd_start ##0 local_addr_hi[7:5] inside {3'h1, 3'h2, 3'h3}
    |=> !upper_section_direction) else $error("bus not turned on modem read");
  a_upper_only_read: assert property (!upper_section_direction |->
    $past(!local_rd_n) && $past(local_addr_hi[7:5]) inside {3'h1, 3'h2, 3'h3})
    else $error("bus turned outside a modem read");
  a_upper_return: assert property (local_rd_n |=> upper_section_direction)
    else $error("bus direction not restored");
  a_modem_select: assert property (s_strobe_start ##0 local_addr_hi[7:5] inside
    {3'h1, 3'h2, 3'h3} |=> modem_cs_n == ~(3'h1 << (local_addr_hi[7:5] - 3'h1)))
    else $error("wrong modem select");
  a_mbx_local_set: assert property (s_host_mbx_wr |=> !local_cpu_mailbox_irq_n)
    else $error("local mailbox irq not set");
  a_mbx_local_clr: assert property (s_rd_start ##0 host_dpr_sel_n
    && {local_addr_hi, lo_reg} == {3'h0, mbg_pkg::MBX_TO_LOCAL} |=> local_cpu_mailbox_irq_n)
    else $error("local mailbox irq not cleared");
  a_mbx_host_set: assert property ($fell(local_wr_n)
    && {local_addr_hi, lo_reg} == {3'h0, mbg_pkg::MBX_TO_HOST} |=> !host_mailbox_irq_n)
    else $error("host mailbox irq not set");
  a_hold_open: assert property ($past(reset_n) && $past(!local_cpu_hold_n)
    |-> !code_xcvr_en_n && !local_cpu_reset_n) else $error("hold does not open code path");
  a_hold_closed: assert property ($past(reset_n) && $past(local_cpu_hold_n)
    |-> code_xcvr_en_n && code_ram_cs_n && local_cpu_reset_n) else $error("code path open");
  a_local_clk_half: assert property ($past(reset_n)
    |-> local_cpu_clk != $past(local_cpu_clk)) else $error("local clock not halved");
  a_bit_period: assert property (seen_reg && tx_bit_clk && !bclk_reg
    |-> bc_reg == 11'(mbg_pkg::BIT_CYCLES)) else $error("bit clock period wrong");
endmodule // mbg_glue_sva
`default_nettype wire

// ==== test/mbg_far_modem.sv ====
// far-end modem model: hears our transmit line and sends it back
// assumes tx_serial is synchronous to core_clk and the line idles high
`default_nettype none
module mbg_far_modem #(
  parameter int unsigned LAG = 37
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic tx_serial,
  output logic rx_serial
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [LAG-1:0] line_reg;
  // line delay, so word sync must be found on a stream not aligned to ours
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      line_reg <= '1;
    end else begin
      line_reg <= {line_reg[LAG-2:0], tx_serial};
    end
  end
  assign rx_serial = line_reg[LAG-1];
endmodule // mbg_far_modem
`default_nettype wire

// ==== test/mbg_modem_glue_tb.sv ====
// self-checking bench for the modem board glue with a looped-back far modem
// assumes clk_en held high and a 100 ns core clock
`default_nettype none
module mbg_modem_glue_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] SYNC = 8'h7e;
  localparam logic [15:0] A_DATA = {mbg_pkg::REGION_MODEM0, 11'h0, mbg_pkg::MDM_DATA_OFS};
  localparam logic [15:0] A_STAT = {mbg_pkg::REGION_MODEM0, 11'h0, mbg_pkg::MDM_STAT_OFS};
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic local_ale = 1'b0;
  logic local_rd_n = 1'b1;
  logic local_wr_n = 1'b1;
  logic [7:0] local_addr_hi = 8'h00;
  logic [7:0] local_ad_in = 8'h00;
  logic host_dpr_sel_n = 1'b1;
  logic host_code_sel_n = 1'b1;
  logic host_wr_n = 1'b1;
  logic [12:0] host_addr = 13'h0000;
  logic local_cpu_hold_n = 1'b0;
  logic [7:0] local_ad_out;
  logic local_ad_oe_n, local_cpu_clk, local_cpu_reset_n, local_cpu_mailbox_irq_n;
  logic dpr_local_cs_n, data_ram_cs_n, modem_irq_n, lower_section_direction;
  logic upper_section_direction, shifter_oe_n, host_mailbox_irq_n, code_ram_cs_n;
  logic code_xcvr_en_n, rx_serial, tx_serial, tx_bit_clk, d, c;
  logic [2:0] modem_cs_n, cs, e;
  logic [7:0] q, b;
  logic [7:0] exp_q[$];
  int n_fail = 0;
  int num_checks = 0;
  int seed = 9112;
  int got;
  mbg_modem_glue #(.SYNC_WORD(SYNC)) i_dut (.core_clk(core_clk), .reset_n(reset_n),
    .clk_en(1'b1), .local_ale(local_ale), .local_rd_n(local_rd_n), .local_wr_n(local_wr_n),
    .local_addr_hi(local_addr_hi), .local_ad_in(local_ad_in), .local_ad_out(local_ad_out),
    .local_ad_oe_n(local_ad_oe_n), .local_cpu_clk(local_cpu_clk),
    .local_cpu_reset_n(local_cpu_reset_n), .local_cpu_mailbox_irq_n(local_cpu_mailbox_irq_n),
    .dpr_local_cs_n(dpr_local_cs_n), .data_ram_cs_n(data_ram_cs_n), .modem_cs_n(modem_cs_n),
    .modem_irq_n(modem_irq_n), .lower_section_direction(lower_section_direction),
    .upper_section_direction(upper_section_direction), .shifter_oe_n(shifter_oe_n),
    .host_dpr_sel_n(host_dpr_sel_n), .host_code_sel_n(host_code_sel_n),
    .host_wr_n(host_wr_n), .host_addr(host_addr), .local_cpu_hold_n(local_cpu_hold_n),
    .host_mailbox_irq_n(host_mailbox_irq_n), .code_ram_cs_n(code_ram_cs_n),
    .code_xcvr_en_n(code_xcvr_en_n), .rx_serial(rx_serial), .tx_serial(tx_serial),
    .tx_bit_clk(tx_bit_clk));
  mbg_far_modem i_far (.core_clk(core_clk), .reset_n(reset_n), .tx_serial(tx_serial),
    .rx_serial(rx_serial));
  // free-running core clock
  always #50 core_clk = ~core_clk;
  ////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got_v, input logic [7:0] exp_v, input string what);
    num_checks++;
    if (got_v !== exp_v) begin
      n_fail++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got_v, exp_v);
    end
  endtask
  // bounded wait on a level, a hang ends the run
  task automatic wait_lvl(ref logic s, input logic v);
    int k;
    k = 0;
    while (s !== v && k < 3000) begin
      @(negedge core_clk);
      k++;
    end
    if (s !== v) begin
      n_fail++;
      $display("[ERR] %0t wait ran out", $time);
      summarize();
    end
  endtask
  // local bus cycle: latch phase, then strobe held two cycles, sampled before release
  task automatic lbus(input logic wr, input logic [15:0] a, input logic [7:0] wd);
    @(negedge core_clk);
    local_ale = 1'b1;
    local_addr_hi = a[15:8];
    local_ad_in = a[7:0];
    @(negedge core_clk);
    local_ale = 1'b0;
    local_ad_in = wd;
    local_wr_n = !wr;
    local_rd_n = wr;
    repeat (2) @(negedge core_clk);
    q = local_ad_out;
    d = upper_section_direction;
    cs = modem_cs_n;
    e = {local_ad_oe_n, dpr_local_cs_n, data_ram_cs_n};
    local_rd_n = 1'b1;
    local_wr_n = 1'b1;
    repeat (2) @(negedge core_clk);
  endtask
  // host port access, select and write level held two cycles
  task automatic host(input logic code, input logic wr, input logic [12:0] a);
    @(negedge core_clk);
    host_addr = a;
    host_wr_n = !wr;
    host_code_sel_n = !code;
    host_dpr_sel_n = code;
    repeat (2) @(negedge core_clk);
    c = code_ram_cs_n;
    host_dpr_sel_n = 1'b1;
    host_code_sel_n = 1'b1;
    host_wr_n = 1'b1;
    @(negedge core_clk);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(negedge core_clk);
    reset_n = 1'b1;
    @(negedge core_clk);
    chk({7'h0, upper_section_direction}, 8'h01, "upper dir idle");
    chk({6'h0, lower_section_direction, shifter_oe_n}, 8'h02, "lower section");
    // code load while held, then release and try again
    host(1'b1, 1'b1, 13'h0005);
    chk({6'h0, c, code_xcvr_en_n}, 8'h00, "code path while held");
    local_cpu_hold_n = 1'b1;
    host(1'b1, 1'b1, 13'h0006);
    chk({5'h0, c, code_xcvr_en_n, local_cpu_reset_n}, 8'h07, "code path released");
    // mailboxes both ways, a neighbouring address must not fire
    host(1'b0, 1'b1, 13'h1ffd);
    chk({7'h0, local_cpu_mailbox_irq_n}, 8'h01, "stray mailbox");
    host(1'b0, 1'b1, mbg_pkg::MBX_TO_LOCAL);
    chk({7'h0, local_cpu_mailbox_irq_n}, 8'h00, "local irq set");
    lbus(1'b0, 16'h1fff, 8'h00);
    chk({7'h0, local_cpu_mailbox_irq_n}, 8'h01, "local irq clear");
    lbus(1'b1, {3'h0, mbg_pkg::MBX_TO_HOST}, 8'h5a);
    chk({7'h0, host_mailbox_irq_n}, 8'h00, "host irq set");
    host(1'b0, 1'b0, mbg_pkg::MBX_TO_HOST);
    chk({7'h0, host_mailbox_irq_n}, 8'h01, "host irq clear");
    // regions 0 to 4: read turns the bus only for modems, a write right after sees it back
    for (int i = 0; i < 5; i++) begin
      lbus(1'b0, {3'(i), 13'h0002}, 8'h00);
      chk({7'h0, d}, (i % 4 == 0) ? 8'h01 : 8'h00, "upper dir on read");
      chk({5'h0, cs}, (i % 4 == 0) ? 8'h07 : {5'h0, ~(3'h1 << (i - 1))}, "modem select");
      chk({5'h0, e}, {5'h0, i != 1, i != 0, i != 4}, "own and memory selects");
      if (i == 1) begin
        chk(q, 8'h00, "reserved offset");
      end
      lbus(1'b1, {3'(i), 13'h0003}, 8'h00);
      chk({7'h0, d}, 8'h01, "dir before write");
    end
    // bytes sent before word sync could never be framed, so wait for it
    for (int k = 0; k < 3000 && q[mbg_pkg::STAT_WORD_SYNC] !== 1'b1; k++) begin
      lbus(1'b0, A_STAT, 8'h00);
    end
    // transmit random bytes, a third write into a full buffer is dropped
    for (int r = 0; r < 3; r++) begin
      wait_lvl(modem_irq_n, 1'b0);
      wait_lvl(tx_bit_clk, 1'b0);
      wait_lvl(tx_bit_clk, 1'b1);
      for (int j = 0; j < 3; j++) begin
        b = 8'($random(seed));
        b = (b == SYNC) ? 8'h00 : b;
        if (j == 2) begin
          lbus(1'b0, A_STAT, 8'h00);
          chk({7'h0, q[mbg_pkg::STAT_TX_ROOM]}, 8'h00, "room when full");
        end else begin
          exp_q.push_back(b);
        end
        lbus(1'b1, A_DATA, b);
      end
      // the looped stream comes back with fill words between our bytes
      got = 0;
      for (int k = 0; k < 6000 && got < 2; k++) begin
        lbus(1'b0, A_STAT, 8'h00);
        if (q[mbg_pkg::STAT_RX_FULL] === 1'b1) begin
          chk({7'h0, modem_irq_n}, 8'h00, "rx irq");
          lbus(1'b0, A_DATA, 8'h00);
          if (q !== SYNC) begin
            chk(q, exp_q.pop_front(), "looped byte");
            got++;
          end
        end
      end
      chk(8'(got), 8'h02, "bytes received");
      lbus(1'b0, A_STAT, 8'h00);
      chk({7'h0, q[mbg_pkg::STAT_WORD_SYNC]}, 8'h01, "word sync");
    end
    summarize();
  end
endmodule // mbg_modem_glue_tb
bind mbg_modem_glue mbg_glue_sva i_sva (.core_clk(core_clk), .reset_n(reset_n),
  .local_ale(local_ale), .local_rd_n(local_rd_n), .local_wr_n(local_wr_n),
  .local_addr_hi(local_addr_hi), .local_ad_in(local_ad_in), .local_cpu_clk(local_cpu_clk),
  .local_cpu_reset_n(local_cpu_reset_n), .local_cpu_mailbox_irq_n(local_cpu_mailbox_irq_n),
  .modem_cs_n(modem_cs_n), .lower_section_direction(lower_section_direction),
  .upper_section_direction(upper_section_direction), .shifter_oe_n(shifter_oe_n),
  .host_dpr_sel_n(host_dpr_sel_n), .host_wr_n(host_wr_n), .host_addr(host_addr),
  .local_cpu_hold_n(local_cpu_hold_n), .host_mailbox_irq_n(host_mailbox_irq_n),
  .code_ram_cs_n(code_ram_cs_n), .code_xcvr_en_n(code_xcvr_en_n), .tx_bit_clk(tx_bit_clk));
`default_nettype wire
